// [dct_map.vh]
// dct_map.vh: register offsets, field positions and reset values of the
// dual counter/timer with demodulation capture and ping-pong mode.
// assumes an APB slave with 32-bit data, one aligned word per register.
`ifndef DCT_MAP_VH
`define DCT_MAP_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define DCT_OFF_NARROW_CTRL   8'h00
`define DCT_OFF_SHARED_CTRL   8'h04
`define DCT_OFF_WIDE_CTRL     8'h08
`define DCT_OFF_NARROW_RELOAD 8'h0C
`define DCT_OFF_RELOAD_LOW    8'h10
`define DCT_OFF_RELOAD_HIGH   8'h14
`define DCT_OFF_CAPTURE_LOW   8'h18
`define DCT_OFF_CAPTURE_HIGH  8'h1C
`define DCT_OFF_IRQ_STATUS    8'h20
`define DCT_OFF_IRQ_MASK      8'h24
`define DCT_OFF_COUNT_VIEW    8'h28

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define DCT_BIT_ENABLE      7
`define DCT_BIT_SINGLE_PASS 6
`define DCT_BIT_WIDE_IE     2
`define DCT_BIT_INPUT_SEL   7
`define DCT_BIT_DEMOD       6
`define DCT_BIT_EDGE_FALL   5
`define DCT_BIT_EDGE_RISE   4
`define DCT_BIT_PP_HI       3
`define DCT_BIT_PP_LO       2
`define DCT_BIT_STAT_FALL   1
`define DCT_BIT_STAT_RISE   0
`define DCT_PP_ON           2'h3
`define DCT_IRQ_NARROW_TO   0
`define DCT_IRQ_WIDE_TO     1
`define DCT_IRQ_CAPTURE     2

// ----------------------------------------------------------------------
// reset and load values
// ----------------------------------------------------------------------
`define DCT_RST_CTRL     8'h00
`define DCT_RST_BYTE     8'h00
`define DCT_RST_IRQ      3'h0
`define DCT_DEMOD_RELOAD 16'hFFFF
`define DCT_TIMEOUT_CNT  1

`endif

// [dct_edge_detect.v]
// dct_edge_detect.v: input pin select and edge detector for the 16-bit counter.
// assumes both pins are synchronous to pclk.
`timescale 1ns/10ps

// ----------------------------------------------------------------------
// edge detector
// ----------------------------------------------------------------------
module dct_edge_detect (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire sel_port2,
  input wire port3_edge_input,
  input wire port2_edge_input,
  output wire rise,
  output wire fall
);
  reg prev_reg; // last sampled level of the chosen pin
  wire level; // chosen pin

  // pin mux: switching pins may look like one edge, software arms after
  assign level = sel_port2 ? port2_edge_input : port3_edge_input;

  // level history, frozen while ce is low
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_reg <= 1'b0;
    end else if (ce) begin
      prev_reg <= level;
    end
  end

  // combinational pulses, valid in the cycle the new level is seen
  assign rise = level & ~prev_reg;
  assign fall = ~level & prev_reg;
endmodule

// [dct_timer.v]
// dct_timer.v: 8-bit and 16-bit counter/timers with APB register access,
// demodulation capture, ping-pong alternation and a masked interrupt.
// assumes pins synchronous to pclk and a well-behaved APB master.
//
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/10ps
`include "dct_map.vh"

module dct_timer (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire port3_edge_input,
  input wire port2_edge_input,
  output reg wide_counter_output,
  output reg irq
);
  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  // control and reload bytes written by software
  reg [7:0] narrow_counter_control_reg, narrow_counter_control_next; // enable, single-pass
  reg [7:0] shared_counter_control_reg, shared_counter_control_next; // pin, mode, edges
  reg [7:0] wide_counter_control_reg, wide_counter_control_next; // enable, mode, ie
  reg [7:0] narrow_reload_reg, narrow_reload_next; // 8-bit initial count
  reg [7:0] wide_reload_low_byte_reg, wide_reload_low_byte_next;
  reg [7:0] wide_reload_high_byte_reg, wide_reload_high_byte_next;
  // hardware-written capture bytes and live counts
  reg [7:0] capture_low_byte_reg, capture_low_byte_next;
  reg [7:0] capture_high_byte_reg, capture_high_byte_next;
  reg [7:0] eight_bit_counter_reg, eight_bit_counter_next;
  reg [15:0] sixteen_bit_counter_reg, sixteen_bit_counter_next;
  reg demod_counting_reg, demod_counting_next; // first edge seen
  reg [2:0] irq_status_reg, irq_status_next; // sticky events
  reg [2:0] irq_mask_reg, irq_mask_next; // 1 lets the event through
  // next values and per-cycle helpers, all combinational
  reg wide_out_next;
  reg irq_next;
  reg [31:0] read_data; // read mux
  reg addr_ok; // address decodes
  reg wr_access, rd_access; // access-phase edges
  reg start_narrow, start_wide; // restart with reload
  reg [2:0] events; // this cycle's interrupt events
  reg edge_hit; // qualifying edge
  wire edge_rise, edge_fall;
  wire pingpong_on;
  wire demod_on;

  // mode decodes: ping-pong for both counter branches, demod for the 16-bit one
  assign pingpong_on = shared_counter_control_reg[`DCT_BIT_PP_HI:`DCT_BIT_PP_LO] == `DCT_PP_ON;
  assign demod_on = shared_counter_control_reg[`DCT_BIT_DEMOD];

  // ----------------------------------------------------------------------
  // edge input
  // ----------------------------------------------------------------------
  // a pin change while armed may look like one edge to the detector
  dct_edge_detect u_edge (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .sel_port2(shared_counter_control_reg[`DCT_BIT_INPUT_SEL]),
    .port3_edge_input(port3_edge_input),
    .port2_edge_input(port2_edge_input),
    .rise(edge_rise),
    .fall(edge_fall)
  );

  // ----------------------------------------------------------------------
  // read mux and decode
  // ----------------------------------------------------------------------
  // data is sampled in the setup cycle, so reads see pre-access state
  always @* begin
    read_data = 32'h00000000;
    addr_ok = 1'b1;
    case (paddr)
      `DCT_OFF_NARROW_CTRL: read_data[7:0] = narrow_counter_control_reg;
      `DCT_OFF_SHARED_CTRL: read_data[7:0] = shared_counter_control_reg;
      `DCT_OFF_WIDE_CTRL: read_data[7:0] = wide_counter_control_reg;
      `DCT_OFF_NARROW_RELOAD: read_data[7:0] = narrow_reload_reg;
      `DCT_OFF_RELOAD_LOW: read_data[7:0] = wide_reload_low_byte_reg;
      `DCT_OFF_RELOAD_HIGH: read_data[7:0] = wide_reload_high_byte_reg;
      `DCT_OFF_CAPTURE_LOW: read_data[7:0] = capture_low_byte_reg;
      `DCT_OFF_CAPTURE_HIGH: read_data[7:0] = capture_high_byte_reg;
      `DCT_OFF_IRQ_STATUS: read_data[2:0] = irq_status_reg;
      `DCT_OFF_IRQ_MASK: read_data[2:0] = irq_mask_reg;
      `DCT_OFF_COUNT_VIEW: read_data[23:0] = {sixteen_bit_counter_reg, eight_bit_counter_reg};
      default: addr_ok = 1'b0; // unmapped: zero data, error
    endcase
  end

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  // writes first, hardware actions after, so hardware wins a same-cycle clash
  always @* begin
    narrow_counter_control_next = narrow_counter_control_reg;
    shared_counter_control_next = shared_counter_control_reg;
    wide_counter_control_next = wide_counter_control_reg;
    narrow_reload_next = narrow_reload_reg;
    wide_reload_low_byte_next = wide_reload_low_byte_reg;
    wide_reload_high_byte_next = wide_reload_high_byte_reg;
    capture_low_byte_next = capture_low_byte_reg;
    capture_high_byte_next = capture_high_byte_reg;
    eight_bit_counter_next = eight_bit_counter_reg;
    sixteen_bit_counter_next = sixteen_bit_counter_reg;
    demod_counting_next = demod_counting_reg;
    irq_mask_next = irq_mask_reg;
    wide_out_next = wide_counter_output;
    events = 3'h0;
    start_narrow = 1'b0;
    start_wide = 1'b0;
    wr_access = psel & penable & pready & pwrite;
    rd_access = psel & penable & pready & ~pwrite;
    edge_hit = (shared_counter_control_reg[`DCT_BIT_EDGE_RISE] & edge_rise) |
               (shared_counter_control_reg[`DCT_BIT_EDGE_FALL] & edge_fall);

    // software writes; a 0 to 1 enable write restarts the counter
    if (wr_access) begin
      case (paddr)
        `DCT_OFF_NARROW_CTRL: begin
          narrow_counter_control_next = pwdata[7:0];
          start_narrow = pwdata[`DCT_BIT_ENABLE] &
                         ~narrow_counter_control_reg[`DCT_BIT_ENABLE];
        end
        `DCT_OFF_SHARED_CTRL: begin
          // status bits are write-one-to-clear
          shared_counter_control_next = {pwdata[7:2],
                                         shared_counter_control_reg[1:0] & ~pwdata[1:0]};
        end
        `DCT_OFF_WIDE_CTRL: begin
          wide_counter_control_next = pwdata[7:0];
          start_wide = pwdata[`DCT_BIT_ENABLE] &
                       ~wide_counter_control_reg[`DCT_BIT_ENABLE];
        end
        `DCT_OFF_NARROW_RELOAD: narrow_reload_next = pwdata[7:0];
        `DCT_OFF_RELOAD_LOW: wide_reload_low_byte_next = pwdata[7:0];
        `DCT_OFF_RELOAD_HIGH: wide_reload_high_byte_next = pwdata[7:0];
        `DCT_OFF_IRQ_MASK: irq_mask_next = pwdata[2:0];
        default: begin
          // read-only or unmapped: ignored
        end
      endcase
    end

    // 8-bit counter: timeout when the count is one, in place of the step to zero
    // ping-pong hands over and single-pass stops at timeout; otherwise the reload comes back
    if (narrow_counter_control_reg[`DCT_BIT_ENABLE] && !start_narrow) begin
      if (eight_bit_counter_reg == `DCT_TIMEOUT_CNT) begin
        events[`DCT_IRQ_NARROW_TO] = 1'b1;
        if (pingpong_on) begin
          // hand over to the 16-bit counter
          narrow_counter_control_next[`DCT_BIT_ENABLE] = 1'b0;
          wide_counter_control_next[`DCT_BIT_ENABLE] = 1'b1;
          start_wide = 1'b1;
        end else if (narrow_counter_control_reg[`DCT_BIT_SINGLE_PASS]) begin
          narrow_counter_control_next[`DCT_BIT_ENABLE] = 1'b0;
        end else begin
          eight_bit_counter_next = narrow_reload_reg;
        end
      end else begin
        eight_bit_counter_next = eight_bit_counter_reg - 8'h01;
      end
    end

    // 16-bit counter
    // demod measures gaps and never times out; only the arming edge captures if mode bit set
    if (wide_counter_control_reg[`DCT_BIT_ENABLE] && !start_wide) begin
      if (demod_on) begin
        if (edge_hit && !demod_counting_reg) begin
          // first edge: capture, reload and start counting
          capture_high_byte_next = ~sixteen_bit_counter_reg[15:8];
          capture_low_byte_next = ~sixteen_bit_counter_reg[7:0];
          sixteen_bit_counter_next = `DCT_DEMOD_RELOAD;
          demod_counting_next = 1'b1;
        end else if (edge_hit && !wide_counter_control_reg[`DCT_BIT_SINGLE_PASS]) begin
          // later edge: complemented count is the space time
          capture_high_byte_next = ~sixteen_bit_counter_reg[15:8];
          capture_low_byte_next = ~sixteen_bit_counter_reg[7:0];
          if (edge_rise) begin
            shared_counter_control_next[`DCT_BIT_STAT_RISE] = 1'b1;
          end else begin
            shared_counter_control_next[`DCT_BIT_STAT_FALL] = 1'b1;
          end
          events[`DCT_IRQ_CAPTURE] = wide_counter_control_reg[`DCT_BIT_WIDE_IE];
          sixteen_bit_counter_next = `DCT_DEMOD_RELOAD;
        end else if (demod_counting_reg) begin
          // no timeout while measuring, the count just wraps
          sixteen_bit_counter_next = sixteen_bit_counter_reg - 16'h0001;
        end
      end else if (sixteen_bit_counter_reg == `DCT_TIMEOUT_CNT) begin
        events[`DCT_IRQ_WIDE_TO] = 1'b1;
        wide_out_next = ~wide_counter_output;
        if (pingpong_on) begin
          // hand over to the 8-bit counter
          wide_counter_control_next[`DCT_BIT_ENABLE] = 1'b0;
          narrow_counter_control_next[`DCT_BIT_ENABLE] = 1'b1;
          start_narrow = 1'b1;
        end else if (wide_counter_control_reg[`DCT_BIT_SINGLE_PASS]) begin
          wide_counter_control_next[`DCT_BIT_ENABLE] = 1'b0;
        end else begin
          sixteen_bit_counter_next = {wide_reload_high_byte_reg, wide_reload_low_byte_reg};
        end
      end else begin
        // zero steps to all ones with no timeout
        sixteen_bit_counter_next = sixteen_bit_counter_reg - 16'h0001;
      end
    end

    // restart loads the initial value, never the stale count
    if (start_narrow) begin
      eight_bit_counter_next = narrow_reload_reg;
    end
    // a wide restart also forgets the arming edge of demodulation
    if (start_wide) begin
      sixteen_bit_counter_next = {wide_reload_high_byte_reg, wide_reload_low_byte_reg};
      demod_counting_next = 1'b0;
    end

    // sticky status: read clears, a same-cycle event wins
    if (rd_access && paddr == `DCT_OFF_IRQ_STATUS) begin
      irq_status_next = events;
    end else begin
      irq_status_next = irq_status_reg | events;
    end
    // built from next values so irq rises with its status bit
    irq_next = |(irq_status_next & irq_mask_next);
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  // everything, bus answer included, holds while ce is low
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      narrow_counter_control_reg <= `DCT_RST_CTRL;
      shared_counter_control_reg <= `DCT_RST_CTRL;
      wide_counter_control_reg <= `DCT_RST_CTRL;
      narrow_reload_reg <= `DCT_RST_BYTE;
      wide_reload_low_byte_reg <= `DCT_RST_BYTE;
      wide_reload_high_byte_reg <= `DCT_RST_BYTE;
      capture_low_byte_reg <= `DCT_RST_BYTE;
      capture_high_byte_reg <= `DCT_RST_BYTE;
      eight_bit_counter_reg <= `DCT_RST_BYTE;
      sixteen_bit_counter_reg <= 16'h0000;
      demod_counting_reg <= 1'b0;
      irq_status_reg <= `DCT_RST_IRQ;
      irq_mask_reg <= `DCT_RST_IRQ;
      wide_counter_output <= 1'b0;
      irq <= 1'b0;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      narrow_counter_control_reg <= narrow_counter_control_next;
      shared_counter_control_reg <= shared_counter_control_next;
      wide_counter_control_reg <= wide_counter_control_next;
      narrow_reload_reg <= narrow_reload_next;
      wide_reload_low_byte_reg <= wide_reload_low_byte_next;
      wide_reload_high_byte_reg <= wide_reload_high_byte_next;
      capture_low_byte_reg <= capture_low_byte_next;
      capture_high_byte_reg <= capture_high_byte_next;
      eight_bit_counter_reg <= eight_bit_counter_next;
      sixteen_bit_counter_reg <= sixteen_bit_counter_next;
      demod_counting_reg <= demod_counting_next;
      irq_status_reg <= irq_status_next;
      irq_mask_reg <= irq_mask_next;
      wide_counter_output <= wide_out_next;
      irq <= irq_next;
      // one wait-free access: ready is raised at the setup edge
      // ready pulses one cycle; the !pready term stops a held setup retriggering
      if (psel && !penable && !pready) begin
        pready <= 1'b1;
        prdata <= pwrite ? 32'h00000000 : read_data;
        pslverr <= ~addr_ok;
      end else begin
        pready <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end
endmodule

// [dct_timer_properties.sv]
// dct_timer_properties.sv: port checker for dct_timer, with its bind.
// assumes pins synchronous to pclk; it learns the control bits from writes.
`timescale 1ns/10ps

module dct_timer_chk (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  input wire port3_edge_input,
  input wire port2_edge_input,
  input wire wide_counter_output,
  input wire irq
);
  reg [7:0] sh_reg; // shared control copy
  reg [7:0] wc_reg; // wide control copy
  reg [2:0] mk_reg; // mask copy
  reg pin_reg; // last pin sample
  reg armed_reg; // arming edge seen
  wire wr = ce && psel && penable && pready && pwrite; // write lands
  wire pin = sh_reg[7] ? port2_edge_input : port3_edge_input; // chosen pin
  wire demod = sh_reg[6] && wc_reg[7]; // capture running
  wire qual = pin != pin_reg && (pin ? sh_reg[4] : sh_reg[5]); // chosen edge kind

  // copies follow writes only; hardware enable changes are not seen,
  // so the capture check is only trusted outside ping-pong
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_reg <= 8'h00;
      wc_reg <= 8'h00;
      mk_reg <= 3'h0;
      pin_reg <= 1'b0;
      armed_reg <= 1'b0;
    end else if (ce) begin
      pin_reg <= pin;
      if (wr && paddr == 8'h04) begin
        sh_reg <= pwdata[7:0];
      end
      if (wr && paddr == 8'h08) begin
        wc_reg <= pwdata[7:0];
      end
      if (wr && paddr == 8'h24) begin
        mk_reg <= pwdata[2:0];
      end
      if (!demod) begin
        armed_reg <= 1'b0; // a restart wants a new arming edge
      end else if (qual) begin
        armed_reg <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_ready_setup: assert property (ce && psel && !penable && !pready |=> pready)
    else $error("no pready after setup");
  chk_ready_pulse: assert property (pready && ce |=> !pready)
    else $error("pready held too long");
  chk_unmapped_err: assert property (pready && paddr > 8'h28 |-> pslverr)
    else $error("unmapped access not refused");
  chk_freeze_hold: assert property (
    !ce |=> $stable(irq) && $stable(wide_counter_output))
    else $error("outputs moved with clock enable low");
  chk_irq_masked: assert property (mk_reg == 3'h0 && $past(mk_reg) == 3'h0 |-> !irq)
    else $error("irq high with all sources masked");
  chk_capture_irq: assert property (
    ce && demod && armed_reg && qual && !wc_reg[6] && wc_reg[2] && mk_reg[2] |-> ##[1:2] irq)
    else $error("capture raised no irq");
  chk_demod_quiet: assert property (
    sh_reg[6] && $past(sh_reg[6]) |-> $stable(wide_counter_output))
    else $error("wide output toggled in capture mode");
  chk_mapped_ok: assert property (pready && paddr <= 8'h28 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
endmodule

bind dct_timer dct_timer_chk chk (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .pslverr, .port3_edge_input, .port2_edge_input, .wide_counter_output, .irq);

// [dct_pulse_src.sv]
// dct_pulse_src.sv: model of the carrier source on the edge pins.
// assumes the bench steers lvl right after a rising pclk edge.
`timescale 1ns/10ps

module dct_pulse_src (
  input wire pclk,
  input wire lvl,
  output wire port3_edge_input,
  output wire port2_edge_input
);
  reg noise_reg = 1'b0; // chatter on the idle pin
  // the unused pin never rests, so a wrong pin choice shows at once
  always @(posedge pclk) noise_reg <= ~noise_reg;
  assign port2_edge_input = lvl; // carrier pin
  assign port3_edge_input = noise_reg;
endmodule

// [tb.sv]
// tb.sv: self-checking bench for dct_timer.
// assumes the checker bind and dct_pulse_src are compiled before it.
`timescale 1ns/10ps

module tb;
  // ---------------------------------
  // signals and rows
  // ---------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0; // low for the first two edges
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic lvl = 1'b0; // carrier level
  logic [31:0] prdata, rd;
  logic pready, pslverr, p3, p2, wout, irq, er, o;
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0; // edges so far
  int st = 0; // edge of last carrier rise
  typedef struct {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] x; logic e;} dct_row_t;
  // reset values, access kinds, refusals; reload set to all ones
  dct_row_t rows [14] = '{
    '{8'h00, 1'b0, 32'h0, 32'h0, 1'b0}, '{8'h04, 1'b0, 32'h0, 32'h0, 1'b0},
    '{8'h08, 1'b0, 32'h0, 32'h0, 1'b0}, '{8'h20, 1'b0, 32'h0, 32'h0, 1'b0},
    '{8'h28, 1'b0, 32'h0, 32'h0, 1'b0}, '{8'h2C, 1'b0, 32'h0, 32'h0, 1'b1},
    '{8'h24, 1'b1, 32'h7, 32'h0, 1'b0}, '{8'h24, 1'b0, 32'h0, 32'h7, 1'b0},
    '{8'h10, 1'b1, 32'hFF, 32'h0, 1'b0}, '{8'h14, 1'b1, 32'hFF, 32'h0, 1'b0},
    '{8'h14, 1'b0, 32'h0, 32'hFF, 1'b0}, '{8'h1C, 1'b1, 32'hAA, 32'h0, 1'b0},
    '{8'h1C, 1'b0, 32'h0, 32'h0, 1'b0}, '{8'h80, 1'b1, 32'h5, 32'h0, 1'b1}};

  dct_timer dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .port3_edge_input(p3), .port2_edge_input(p2),
    .wide_counter_output(wout), .irq);
  dct_pulse_src src (.pclk, .lvl, .port3_edge_input(p3), .port2_edge_input(p2));

  initial begin
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) cyc <= cyc + 1;

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // one transfer, entered just after a rising edge; ends with an idle edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // ready, data and error are taken at the rising edge that shows ready high
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_count++; // slave never answered
      report_and_stop();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rdx(input string nm, input logic [7:0] a, input logic [31:0] x);
    apb(a, 1'b0, 32'h0);
    check(nm, rd, x);
  endtask

  // bounded wait for the wide output to flip
  task automatic wait_toggle(input int lim);
    o = wout;
    for (int n = 0; n < lim && wout === o; n++) @(posedge pclk);
    check("toggle", {31'h0, wout !== o}, 32'h1);
    if (wout === o) begin
      report_and_stop(); // bound used up
    end
  endtask

  task automatic rise_at(input int t);
    while (cyc < t) @(posedge pclk);
    lvl <= 1'b1;
    st = cyc;
  endtask

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 14; i++) begin
      apb(rows[i].a, rows[i].w, rows[i].d);
      check("pslverr", {31'h0, er}, {31'h0, rows[i].e});
      if (!rows[i].w) begin
        check("rdata", rd, rows[i].x);
      end
    end
    // capture on port2 rising edges, irq enabled
    apb(8'h04, 1'b1, 32'hD0);
    apb(8'h08, 1'b1, 32'h84);
    rise_at(cyc + 2); // arming edge
    repeat (5) @(posedge pclk);
    lvl <= 1'b0; // falling edge, not selected
    check("irq idle", {31'h0, irq}, 32'h0);
    rise_at(st + 300);
    repeat (4) @(posedge pclk);
    check("irq on", {31'h0, irq}, 32'h1);
    lvl <= 1'b0;
    rdx("cap low", 8'h18, 32'h2B);
    rdx("cap high", 8'h1C, 32'h01);
    rdx("status", 8'h20, 32'h4);
    rdx("edge flag", 8'h04, 32'hD1);
    apb(8'h08, 1'b1, 32'h80); // irq enable off
    apb(8'h04, 1'b1, 32'hD1); // clear rising flag
    rise_at(st + 60);
    repeat (4) @(posedge pclk);
    check("irq off", {31'h0, irq}, 32'h0);
    lvl <= 1'b0;
    rdx("status off", 8'h20, 32'h0);
    rdx("edge flag", 8'h04, 32'hD1);
    rdx("cap low", 8'h18, 32'h3B);
    rdx("cap high", 8'h1C, 32'h00);
    // falling edges only: the rise is ignored, the fall captures
    apb(8'h04, 1'b1, 32'hE3);
    lvl <= 1'b1;
    repeat (20) @(posedge pclk);
    lvl <= 1'b0;
    repeat (4) @(posedge pclk);
    rdx("fall flag", 8'h04, 32'hE2);
    rdx("fall cap low", 8'h18, 32'h26);
    rdx("fall cap high", 8'h1C, 32'h00);
    apb(8'h08, 1'b1, 32'h00);
    apb(8'h04, 1'b1, 32'h00);
    // zero start wraps with no timeout, clock enable paused meanwhile
    apb(8'h10, 1'b1, 32'h0);
    apb(8'h14, 1'b1, 32'h0);
    o = wout;
    apb(8'h08, 1'b1, 32'h80);
    ce <= 1'b0;
    repeat (3) @(posedge pclk);
    ce <= 1'b1;
    apb(8'h28, 1'b0, 32'h0);
    check("wrap", {24'h0, rd[23:16]}, 32'hFF);
    check("no toggle", {31'h0, wout}, {31'h0, o});
    rdx("no flag", 8'h20, 32'h0);
    // stop, new reload, restart
    apb(8'h08, 1'b1, 32'h00);
    apb(8'h10, 1'b1, 32'h10);
    apb(8'h08, 1'b1, 32'h80);
    apb(8'h28, 1'b0, 32'h0);
    check("restart", {16'h0, rd[23:8]}, 32'h0000000F);
    wait_toggle(40);
    rdx("timeout flag", 8'h20, 32'h2);
    // ping-pong: stop, select, single-pass both, then start the narrow one
    apb(8'h08, 1'b1, 32'h00);
    apb(8'h04, 1'b1, 32'h0C);
    apb(8'h00, 1'b1, 32'h40);
    apb(8'h08, 1'b1, 32'h40);
    apb(8'h0C, 1'b1, 32'h05);
    apb(8'h10, 1'b1, 32'h08);
    apb(8'h20, 1'b0, 32'h0);
    apb(8'h00, 1'b1, 32'hC0);
    wait_toggle(60);
    check("pp irq", {31'h0, irq}, 32'h1);
    rdx("pp flags", 8'h20, 32'h3);
    // second reset in mid-run
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check("rst irq", {31'h0, irq}, 32'h0);
    check("rst out", {31'h0, wout}, 32'h0);
    presetn <= 1'b1;
    @(posedge pclk);
    rdx("rst narrow", 8'h00, 32'h0);
    rdx("rst shared", 8'h04, 32'h0);
    report_and_stop();
  end
endmodule
